// file: fcc_pkg.sv
// Constants shared by the fieldbus slave configuration check.
// Assumes one 100 MHz system clock and an active-low asynchronous reset.
package fcc_pkg;

    // ------------------------------------------------------------------
    // Identification codes sent per extension module
    // ------------------------------------------------------------------
    localparam logic [7:0] FCC_ID_BYTE_IN = 8'h10;
    localparam logic [7:0] FCC_ID_WORD_IN = 8'h50;
    localparam logic [7:0] FCC_ID_BYTE_OUT = 8'h20;
    localparam logic [7:0] FCC_ID_WORD_OUT = 8'h60;

    // ------------------------------------------------------------------
    // Extension module type codes on the internal chain
    // ------------------------------------------------------------------
    localparam int FCC_TYPE_W = 3;
    localparam logic [2:0] FCC_MT_BYTE_IN = 3'h0;
    localparam logic [2:0] FCC_MT_WORD_IN = 3'h1;
    localparam logic [2:0] FCC_MT_BYTE_OUT = 3'h2;
    localparam logic [2:0] FCC_MT_WORD_OUT = 3'h3;
    localparam logic [2:0] FCC_MT_BYTE_IN_OUT = 3'h4;

    // ------------------------------------------------------------------
    // Station number range and digit limits
    // ------------------------------------------------------------------
    localparam logic [3:0] FCC_DIGIT_MAX = 4'h9;
    localparam logic [6:0] FCC_TENS_WEIGHT = 7'h0A;
    localparam logic [6:0] FCC_ADDR_MIN = 7'h01;
    localparam logic [6:0] FCC_ADDR_MAX = 7'h63;

    // ------------------------------------------------------------------
    // Default sizes
    // ------------------------------------------------------------------
    localparam int FCC_MAX_MOD = 16;
    localparam int FCC_MAX_ID = 32;

endpackage : fcc_pkg

// file: fcc_config_check.sv
// Station-number capture and configuration identification check of a fieldbus I/O head station.
// Assumes switch and supply-sense pins are asynchronous; module list and master bytes come from clk logic.
//
// Summary of operation
// - Station number is tens switch times ten plus ones.
// - Only station numbers one to ninety-nine valid.
// - Switches sampled only when supply becomes present.
// - One identification entry per module, two for a byte in/out module, consecutive order.
// - Data exchange only on exact configuration match.
// - Eight input bits give code 10 hex.
// - Sixteen input bits give code 50 hex.
// - Eight output bits give code 20 hex.
// - Sixteen output bits give code 60 hex.
`timescale 1ns/10ps
module fcc_config_check
    import fcc_pkg::*;
#(
    parameter int MAX_MOD = FCC_MAX_MOD,
    parameter int MAX_ID = FCC_MAX_ID
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] tens_digit_switch,
    input wire logic [3:0] ones_digit_switch,
    input wire logic operating_supply_voltage,
    input wire logic [$clog2(MAX_MOD+1)-1:0] module_count,
    input wire logic [MAX_MOD*FCC_TYPE_W-1:0] module_types,
    input wire logic cfg_start,
    input wire logic cfg_valid,
    input wire logic [7:0] cfg_byte,
    input wire logic cfg_end,
    output logic [6:0] station_addr,
    output logic addr_valid,
    output logic [$clog2(MAX_ID+1)-1:0] ident_len,
    output logic cfg_ready,
    output logic cfg_mismatch,
    output logic data_exchange_en
);

    localparam int MW = $clog2(MAX_MOD+1);
    localparam int IW = $clog2(MAX_ID+1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FCC_IDLE,
        FCC_BUILD,
        FCC_READY
    } fcc_phase_t;

    // All state lives in one record so that reset and the next-state copy always stay in step.
    typedef struct packed {
        fcc_phase_t phase;
        logic [3:0] tens_s1;
        logic [3:0] tens_s2;
        logic [3:0] ones_s1;
        logic [3:0] ones_s2;
        logic sup_s1;
        logic sup_s2;
        logic captured;
        logic [6:0] addr;
        logic addr_ok;
        logic [MW-1:0] mod_idx;
        logic second;
        logic [MAX_ID-1:0][7:0] ids;
        logic [IW-1:0] id_len;
        logic in_cfg;
        logic [IW-1:0] cmp_idx;
        logic mismatch;
        logic exch;
        logic ready;
    } fcc_state_t;

    fcc_state_t s_q;
    fcc_state_t s_d;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Type codes 5 to 7 are unused; they fall back to the byte-input code rather than leave the lane unknown.
    function automatic logic [7:0] fcc_id_code(input logic [2:0] mtype, input logic second);
        logic [7:0] code;
        code = FCC_ID_BYTE_IN;
        case (mtype)
            FCC_MT_BYTE_IN: code = FCC_ID_BYTE_IN;
            FCC_MT_WORD_IN: code = FCC_ID_WORD_IN;
            FCC_MT_BYTE_OUT: code = FCC_ID_BYTE_OUT;
            FCC_MT_WORD_OUT: code = FCC_ID_WORD_OUT;
            FCC_MT_BYTE_IN_OUT: code = second ? FCC_ID_BYTE_OUT : FCC_ID_BYTE_IN;
            default: code = FCC_ID_BYTE_IN;
        endcase
        return code;
    endfunction : fcc_id_code

    // Digits above nine can wrap the seven-bit sum; the digit check, not the range check, rejects them.
    function automatic logic [6:0] fcc_bcd_to_bin(input logic [3:0] tens, input logic [3:0] ones);
        logic [13:0] prod;
        prod = {3'h0, tens} * FCC_TENS_WEIGHT;
        return 7'(prod) + {3'h0, ones};
    endfunction : fcc_bcd_to_bin

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0] mtype;
        logic [6:0] bin;
        s_d = s_q;
        mtype = module_types[s_q.mod_idx*FCC_TYPE_W +: FCC_TYPE_W];
        bin = fcc_bcd_to_bin(s_q.tens_s2, s_q.ones_s2);

        // Two stages per pin; only the second stage feeds the capture logic.
        s_d.tens_s1 = tens_digit_switch;
        s_d.tens_s2 = s_q.tens_s1;
        s_d.ones_s1 = ones_digit_switch;
        s_d.ones_s2 = s_q.ones_s1;
        s_d.sup_s1 = operating_supply_voltage;
        s_d.sup_s2 = s_q.sup_s1;

        if (!s_q.sup_s2) begin
            // Losing the supply clears the capture flag, station validity and exchange, so the next power-up re-reads the switches.
            s_d.captured = 1'b0;
            s_d.addr_ok = 1'b0;
            s_d.exch = 1'b0;
            s_d.in_cfg = 1'b0;
            s_d.phase = FCC_IDLE;
        end else begin
            case (s_q.phase)
                FCC_IDLE: begin
                    if (!s_q.captured) begin
                        // Switches are read once per supply cycle; later turns are ignored.
                        s_d.captured = 1'b1;
                        s_d.addr = bin;
                        // Rotary switches can show A to F as well, so each digit is checked on its own.
                        s_d.addr_ok = (s_q.tens_s2 <= FCC_DIGIT_MAX) && (s_q.ones_s2 <= FCC_DIGIT_MAX)
                                      && (bin >= FCC_ADDR_MIN) && (bin <= FCC_ADDR_MAX);
                        s_d.mod_idx = '0;
                        s_d.second = 1'b0;
                        s_d.id_len = '0;
                        s_d.mismatch = 1'b0;
                        s_d.phase = FCC_BUILD;
                    end
                end
                FCC_BUILD: begin
                    // The chain is walked from the module nearest the head station outward.
                    // A list longer than MAX_ID is cut short, so the master sees a mismatch, never a false match.
                    if (s_q.mod_idx >= module_count || s_q.mod_idx >= MW'(MAX_MOD)
                            || s_q.id_len >= IW'(MAX_ID)) begin
                        s_d.phase = FCC_READY;
                    end else begin
                        s_d.ids[s_q.id_len] = fcc_id_code(mtype, s_q.second);
                        s_d.id_len = s_q.id_len + IW'(1);
                        if (mtype == FCC_MT_BYTE_IN_OUT && !s_q.second) begin
                            s_d.second = 1'b1;
                        end else begin
                            s_d.second = 1'b0;
                            s_d.mod_idx = s_q.mod_idx + MW'(1);
                        end
                    end
                end
                FCC_READY: begin
                    // A new telegram closes the exchange at once; it opens again only after a full match.
                    if (cfg_start) begin
                        s_d.in_cfg = 1'b1;
                        s_d.cmp_idx = '0;
                        s_d.mismatch = 1'b0;
                        s_d.exch = 1'b0;
                    end else if (s_q.in_cfg && cfg_valid) begin
                        if (s_q.cmp_idx >= s_q.id_len || cfg_byte != s_q.ids[s_q.cmp_idx]) begin
                            s_d.mismatch = 1'b1;
                        end
                        // The index saturates so that a long telegram cannot wrap around onto a match.
                        if (s_q.cmp_idx < IW'(MAX_ID)) begin
                            s_d.cmp_idx = s_q.cmp_idx + IW'(1);
                        end
                    end else if (s_q.in_cfg && cfg_end) begin
                        s_d.in_cfg = 1'b0;
                        // An invalid station number never opens the exchange.
                        s_d.exch = !s_q.mismatch && (s_q.cmp_idx == s_q.id_len) && s_q.addr_ok;
                        // Too few bytes only shows here, at the end of the telegram.
                        s_d.mismatch = s_q.mismatch || (s_q.cmp_idx != s_q.id_len);
                    end
                end
                // An illegal phase code parks in idle until the supply is cycled.
                default: begin
                    s_d.phase = FCC_IDLE;
                end
            endcase
        end

        // The ready output has its own flop so that it comes straight from a register, not from a decode.
        s_d.ready = (s_d.phase == FCC_READY);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset leaves the phase idle and the capture flag clear, so a supply present at release is a fresh power-up.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The station number keeps its last value while the supply is off; only addr_valid says whether it counts.
    assign station_addr = s_q.addr;
    assign addr_valid = s_q.addr_ok;
    assign ident_len = s_q.id_len;
    assign cfg_ready = s_q.ready;
    assign cfg_mismatch = s_q.mismatch;
    assign data_exchange_en = s_q.exch;

endmodule : fcc_config_check

// file: fcc_sva.sv
// Port-level assertions for the fieldbus slave configuration check.
// Assumes switch pins hold still for some cycles after each power-up.
`timescale 1ns/10ps
module fcc_sva
    import fcc_pkg::*;
#(parameter int MAX_MOD = FCC_MAX_MOD, parameter int MAX_ID = FCC_MAX_ID) (
    input wire logic clk, input wire logic rstn, input wire logic operating_supply_voltage,
    input wire logic [3:0] tens_digit_switch, input wire logic [3:0] ones_digit_switch,
    input wire logic cfg_start, input wire logic cfg_end, input wire logic [6:0] station_addr,
    input wire logic addr_valid, input wire logic [$clog2(MAX_ID+1)-1:0] ident_len,
    input wire logic cfg_ready, input wire logic cfg_mismatch, input wire logic data_exchange_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_sum; $rose(addr_valid) |-> station_addr == tens_digit_switch * 10 + ones_digit_switch; endproperty
    a_sum: assert property (p_sum) else $error("station number not tens and ones");
    property p_range; addr_valid |-> station_addr inside {[7'h01:7'h63]}; endproperty
    a_range: assert property (p_range) else $error("valid station out of range");
    property p_hold; addr_valid && $past(addr_valid) |-> $stable(station_addr); endproperty
    a_hold: assert property (p_hold) else $error("station number moved while powered");
    // Four low samples cover the two-stage synchroniser plus the clearing edge.
    property p_loss; !operating_supply_voltage [*4] |=> !addr_valid && !data_exchange_en; endproperty
    a_loss: assert property (p_loss) else $error("state kept after supply loss");
    property p_build; $rose(addr_valid) |-> ##[0:40] cfg_ready; endproperty
    a_build: assert property (p_build) else $error("identification build too slow");
    property p_len; cfg_ready |-> ident_len <= MAX_ID; endproperty
    a_len: assert property (p_len) else $error("identification too long");
    property p_en; $rose(data_exchange_en) |-> $past(cfg_end && cfg_ready && !cfg_start) && !cfg_mismatch; endproperty
    a_en: assert property (p_en) else $error("exchange enabled without a matching end");
    property p_start; cfg_start && cfg_ready |=> !data_exchange_en; endproperty
    a_start: assert property (p_start) else $error("exchange kept over a new telegram");
    property p_addr_ok; data_exchange_en |-> addr_valid; endproperty
    a_addr_ok: assert property (p_addr_ok) else $error("exchange without valid station");
    c_en: cover property ($rose(data_exchange_en));
    c_mis: cover property ($rose(cfg_mismatch));
    c_cap: cover property ($rose(addr_valid));
endmodule : fcc_sva
bind fcc_config_check fcc_sva #(.MAX_MOD(MAX_MOD), .MAX_ID(MAX_ID)) u_sva (.clk(clk), .rstn(rstn),
    .operating_supply_voltage(operating_supply_voltage), .tens_digit_switch(tens_digit_switch),
    .ones_digit_switch(ones_digit_switch), .cfg_start(cfg_start), .cfg_end(cfg_end), .station_addr(station_addr),
    .addr_valid(addr_valid), .ident_len(ident_len), .cfg_ready(cfg_ready), .cfg_mismatch(cfg_mismatch),
    .data_exchange_en(data_exchange_en));

// file: fcc_master_model.sv
// Behavioural bus master sending one configuration telegram per go request.
// Assumes the bench waits for cfg_ready before asking; slow adds a gap after each byte.
`timescale 1ns/10ps
module fcc_master_model (
    input wire logic clk, input wire logic go, input wire logic slow, input wire logic [3:0] n,
    input wire logic [79:0] bytes, output logic cfg_start, output logic cfg_valid,
    output logic [7:0] cfg_byte, output logic cfg_end, output logic busy
);
    initial begin
        {cfg_start, cfg_valid, cfg_byte, cfg_end, busy} = '0;
        forever begin
            @(posedge clk);
            if (go && !busy) begin
                busy <= 1'b1;
                cfg_start <= 1'b1;
                @(posedge clk);
                cfg_start <= 1'b0;
                for (int i = 0; i < n; i++) begin
                    cfg_valid <= 1'b1;
                    cfg_byte <= bytes[8*i+:8];
                    @(posedge clk);
                    // Outside a valid cycle the byte lane must not look meaningful.
                    if (slow) begin
                        cfg_valid <= 1'b0;
                        cfg_byte <= ~bytes[8*i+:8];
                        @(posedge clk);
                    end
                end
                cfg_valid <= 1'b0;
                cfg_byte <= cfg_byte ^ 8'hA5;
                cfg_end <= 1'b1;
                @(posedge clk);
                cfg_end <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule : fcc_master_model

// file: fcc_config_check_tb.sv
// Self-checking bench: power-ups with corner and random switch and module settings.
// Assumes fcc_master_model plays the master and fcc_sva is bound to the design.
`timescale 1ns/10ps
module fcc_config_check_tb;
    logic clk = 1'b0, rstn = 1'b0, operating_supply_voltage = 1'b0, go = 1'b0, slow = 1'b0;
    logic [3:0] tens_digit_switch = 4'h0, ones_digit_switch = 4'h0, m_n = 4'h0, ident_len;
    logic [2:0] module_count = 3'h0;
    logic [14:0] module_types = 15'h0000;
    logic [79:0] m_b = '0;
    logic busy, cfg_start, cfg_valid, cfg_end, cfg_ready, cfg_mismatch, data_exchange_en, addr_valid;
    logic [7:0] cfg_byte;
    logic [6:0] station_addr;
    int miscompares = 0, comparisons = 0;
    fcc_config_check #(.MAX_MOD(5), .MAX_ID(10)) u_dut (.clk, .rstn, .tens_digit_switch, .ones_digit_switch,
        .operating_supply_voltage, .module_count, .module_types, .cfg_start, .cfg_valid, .cfg_byte, .cfg_end,
        .station_addr, .addr_valid, .ident_len, .cfg_ready, .cfg_mismatch, .data_exchange_en);
    fcc_master_model u_master (.clk, .go, .slow, .n(m_n), .bytes(m_b), .cfg_start, .cfg_valid, .cfg_byte,
        .cfg_end, .busy);
    initial forever #5 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    function automatic int ident(input logic [14:0] ty, input int n, output logic [79:0] b);
        logic [39:0] code;
        int k;
        code = {8'h10, 8'h60, 8'h20, 8'h50, 8'h10};
        k = 0;
        b = '0;
        for (int i = 0; i < n; i++) begin
            b[8*k+:8] = code[8*ty[3*i+:3]+:8];
            k++;
            if (ty[3*i+:3] == 3'h4) begin
                b[8*k+:8] = 8'h20;
                k++;
            end
        end
        return k;
    endfunction : ident
    task automatic run(input logic [3:0] t10, input logic [3:0] t1, input logic [14:0] ty, input logic [2:0] n,
                       input int bad);
        logic [79:0] b;
        int len, w;
        logic ok;
        len = ident(ty, n, b);
        ok = t10 <= 4'h9 && t1 <= 4'h9 && t10 * 10 + t1 > 0;
        @(posedge clk);
        operating_supply_voltage <= 1'b0;
        tens_digit_switch <= t10;
        ones_digit_switch <= t1;
        module_count <= n;
        module_types <= ty;
        repeat (4) @(posedge clk);
        operating_supply_voltage <= 1'b1;
        w = 0;
        do begin
            @(negedge clk);
            w++;
        end while (cfg_ready !== 1'b1 && w < 60);
        chk("ready wait", w < 60, 1'b1);
        chk("addr_valid", addr_valid, ok);
        if (ok)
            chk("station_addr", station_addr, t10 * 10 + t1);
        chk("ident_len", ident_len, len);
        @(posedge clk);
        tens_digit_switch <= t10 ^ 4'h1;
        ones_digit_switch <= t1 ^ 4'h2;
        repeat (5) @(negedge clk);
        if (ok)
            chk("station_addr held", station_addr, t10 * 10 + t1);
        @(posedge clk);
        m_n <= 4'(bad == 2 ? len - 1 : len);
        m_b <= bad == 1 ? b ^ 80'h1 : b;
        slow <= 1'($urandom % 2);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        w = 0;
        do begin
            @(negedge clk);
            w++;
        end while (busy !== 1'b0 && w < 60);
        @(negedge clk);
        chk("data_exchange_en", data_exchange_en, ok && bad == 0);
        chk("cfg_mismatch", cfg_mismatch, bad != 0);
        $display("test done: switches %0h %0h modules %0d fault %0d", t10, t1, n, bad);
    endtask : run
    initial begin
        logic [14:0] ty;
        void'($urandom(90));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        run(4'h9, 4'h9, 15'h4688, 3'h5, 0);
        run(4'h0, 4'h1, 15'h0004, 3'h1, 1);
        run(4'h0, 4'h0, 15'h0001, 3'h1, 0);
        run(4'hA, 4'h2, 15'h0003, 3'h1, 0);
        run(4'h5, 4'h1, 15'h0012, 3'h2, 2);
        // A reset with the supply still present acts as a power-up and re-reads the turned switches (3 and 5).
        run(4'h2, 4'h7, 15'h0000, 3'h1, 0);
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        chk("data_exchange_en in reset", data_exchange_en, 1'b0);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (20) @(negedge clk);
        chk("cfg_ready after reset", cfg_ready, 1'b1);
        chk("station_addr after reset", station_addr, 7'h23);
        chk("data_exchange_en after reset", data_exchange_en, 1'b0);
        $display("test done: reset while exchanging");
        repeat (8) begin
            for (int i = 0; i < 5; i++)
                ty[3*i+:3] = 3'($urandom % 5);
            run(4'($urandom % 10), 4'($urandom % 10), ty, 3'(1 + $urandom % 5), $urandom % 3);
        end
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : fcc_config_check_tb
